// ===== design/sdrpd_pkg.sv
package sdrpd_pkg;
  // ----------------------------------------------------------------
  // sizes and reset values
  // ----------------------------------------------------------------
  localparam int NUM_BANKS = 8;
  localparam int BA_W = 3;
  localparam int ROW_W = 14;
  localparam int CNT_W = 8;
  localparam logic [ROW_W-1:0] ROW_CNT_RST = 14'h0000;
  // ----------------------------------------------------------------
  // timing (clock period 50 ns)
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int CLOSE_TO_OPEN_NS = 15;
  // least time rounds up to whole cycles, never below one
  localparam int CLOSE_TO_OPEN_CYC_RAW = (CLOSE_TO_OPEN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLOSE_TO_OPEN_CYC = (CLOSE_TO_OPEN_CYC_RAW < 1) ? 1 : CLOSE_TO_OPEN_CYC_RAW;
  localparam int CLOSE_ALL_SETTLE_CYC = CLOSE_TO_OPEN_CYC + 1;
  localparam int WRITE_DELAY_CYC = 3;
  localparam int BURST_SIZE = 4;
  localparam int POST_STORE_DELAY_CYC = 3;
  localparam int CKE_PIPE = 2;
  // ----------------------------------------------------------------
  // command codes {ras_n, cas_n, we_n}
  // ----------------------------------------------------------------
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_CLOSE = 3'h2;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_READ = 3'h5;
  localparam logic [2:0] CMD_MRL = 3'h0;
  localparam logic [2:0] CMD_RENEW = 3'h1;
  localparam logic [2:0] CMD_NOP = 3'h7;
  typedef enum logic [3:0] {
    SDRPD_ST_RUN = 4'h1,
    SDRPD_ST_PD = 4'h2,
    SDRPD_ST_SELF = 4'h4,
    SDRPD_ST_RSV = 4'h8
  } sdrpd_state_t;
  typedef enum logic [7:0] {
    SDRPD_C_NONE = 8'h01,
    SDRPD_C_ACT = 8'h02,
    SDRPD_C_CLOSE = 8'h04,
    SDRPD_C_WRITE = 8'h08,
    SDRPD_C_READ = 8'h10,
    SDRPD_C_MRL = 8'h20,
    SDRPD_C_RENEW = 8'h40,
    SDRPD_C_NOP = 8'h80
  } sdrpd_cmd_t;
endpackage

// ===== design/sdrpd_bank.sv
`timescale 1ns/10ps
// per-bank open/close tracking with close settle and write auto-close timer
module sdrpd_bank (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic act,
  input wire logic close,
  input wire logic wr_ap,
  output logic is_open,
  output logic settled,
  output logic ap_fire
);
  localparam logic [7:0] AP_WAIT = 8'(sdrpd_pkg::WRITE_DELAY_CYC
    + sdrpd_pkg::BURST_SIZE / 2 + sdrpd_pkg::POST_STORE_DELAY_CYC);
  localparam logic [7:0] SETTLE = 8'(sdrpd_pkg::CLOSE_ALL_SETTLE_CYC);
  logic [7:0] ap_cnt_q;
  logic [7:0] settle_cnt_q;
  logic ap_pend_q;
  assign ap_fire = ap_pend_q && (ap_cnt_q == 8'h01);
  // auto-close timer: burst end plus post-store delay
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ap_pend_q <= 1'b0;
      ap_cnt_q <= 8'h00;
    end else if (wr_ap) begin
      ap_pend_q <= 1'b1; // see R1
      ap_cnt_q <= AP_WAIT;
    end else if (ap_fire || close) begin
      ap_pend_q <= 1'b0;
    end else if (ap_pend_q) begin
      ap_cnt_q <= ap_cnt_q - 8'h01;
    end
  end
  // open flag
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      is_open <= 1'b0;
    end else if (close || ap_fire) begin
      is_open <= 1'b0;
    end else if (act) begin
      is_open <= 1'b1;
    end
  end
  // settle timed from latest close of this bank
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      settle_cnt_q <= 8'h00;
    end else if (close || ap_fire) begin
      settle_cnt_q <= SETTLE; // see R6
    end else if (settle_cnt_q != 8'h00) begin
      settle_cnt_q <= settle_cnt_q - 8'h01;
    end
  end
  assign settled = !is_open && (settle_cnt_q == 8'h00);
endmodule // sdrpd_bank

// ===== design/sdrpd_top.sv
`timescale 1ns/10ps
// What the document asks of this block and of its controller
// R1 - write with A10 high closes the bank after burst plus post-store delay
// R2 - controller reopens after post-store plus close time and open spacing
// R3 - controller waits read-to-close spacing before closing
// R4 - controller waits write-to-close spacing before closing
// R5 - controller spaces close commands by at least one clock
// R6 - close period runs from latest close to bank, settle is close time plus one
// R7 - controller refreshes every row within 64 ms
// R8 - CS RAS CAS low WE high decodes as renew, row counter internal
// R9 - controller renews only after all banks closed and settled
// R10 - gate registered low with NOP or deselect enters power-down
// R11 - controller keeps gate high during mode load, read and write
// R12 - controller keeps delay loop locked at entry or resets it after
// R13 - all idle gives precharged power-down, else active; loop state follows
// R14 - controller keeps gate low for min pulse and limits stay
// R15 - gate registered high with NOP or deselect exits power-down
// R16 - controller changes clock only in precharged power-down
// R17 - controller resets delay loop with mode load after frequency change
// R18 - commands decoded from CS RAS CAS WE at rising edge
// R19 - A10 on close selects all banks, on read/write selects auto-close; block auto-closes on write only, read ignores A10
// R20 - bank bits select bank or mode register
// R21 - controller never interrupts bursts of four
// R22 - renew with gate falling enters self refresh, gate rising exits
// R23 - controller enters self refresh only with all banks idle
// R24 - controller holds each gate level for three edges
module sdrpd_top #(
  parameter int NUM_BANKS = sdrpd_pkg::NUM_BANKS
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic clk_gate,
  input wire logic a10,
  input wire logic [sdrpd_pkg::BA_W-1:0] ba,
  input wire logic fast_exit,
  output logic [NUM_BANKS-1:0] bank_open,
  output logic all_idle,
  output logic powered_down,
  output logic active_pd,
  output logic self_refresh,
  output logic dll_enabled,
  output logic renew_pulse,
  output logic [sdrpd_pkg::ROW_W-1:0] renew_row,
  output logic mrl_pulse,
  output logic [sdrpd_pkg::BA_W-1:0] mrl_sel
);
  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  sdrpd_pkg::sdrpd_cmd_t cmd;
  sdrpd_pkg::sdrpd_state_t st_q;
  logic gate_prev_q;
  logic nop_or_desel;
  logic running;
  logic [NUM_BANKS-1:0] settled;
  logic [NUM_BANKS-1:0] ap_fire;
  // decode on the sampled pins, gate high required for normal commands
  always_comb begin
    if (cs_n) begin
      cmd = sdrpd_pkg::SDRPD_C_NONE;
    end else begin
      case ({ras_n, cas_n, we_n}) // see R18
        sdrpd_pkg::CMD_ACT: cmd = sdrpd_pkg::SDRPD_C_ACT;
        sdrpd_pkg::CMD_CLOSE: cmd = sdrpd_pkg::SDRPD_C_CLOSE;
        sdrpd_pkg::CMD_WRITE: cmd = sdrpd_pkg::SDRPD_C_WRITE;
        sdrpd_pkg::CMD_READ: cmd = sdrpd_pkg::SDRPD_C_READ;
        sdrpd_pkg::CMD_MRL: cmd = sdrpd_pkg::SDRPD_C_MRL;
        sdrpd_pkg::CMD_RENEW: cmd = sdrpd_pkg::SDRPD_C_RENEW;
        sdrpd_pkg::CMD_NOP: cmd = sdrpd_pkg::SDRPD_C_NOP;
        default: cmd = sdrpd_pkg::SDRPD_C_NOP;
      endcase
    end
  end
  assign nop_or_desel = (cmd == sdrpd_pkg::SDRPD_C_NONE) || (cmd == sdrpd_pkg::SDRPD_C_NOP);
  assign running = (st_q == sdrpd_pkg::SDRPD_ST_RUN) && gate_prev_q && clk_gate;
  // ----------------------------------------------------------------
  // banks
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_BANKS; gi++) begin : g_bank
      logic hit;
      assign hit = (ba == sdrpd_pkg::BA_W'(gi)); // see R20
      sdrpd_bank u_bank (
        .mclk(mclk),
        .arst_n(arst_n),
        .act(running && cmd == sdrpd_pkg::SDRPD_C_ACT && hit),
        .close(running && cmd == sdrpd_pkg::SDRPD_C_CLOSE && (a10 || hit)), // see R19
        .wr_ap(running && cmd == sdrpd_pkg::SDRPD_C_WRITE && a10 && hit), // see R1
        .is_open(bank_open[gi]),
        .settled(settled[gi]),
        .ap_fire(ap_fire[gi])
      );
    end
  endgenerate
  assign all_idle = (bank_open == '0);
  // ----------------------------------------------------------------
  // gate history and power state
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      gate_prev_q <= 1'b1;
    end else begin
      gate_prev_q <= clk_gate;
    end
  end
  // power state machine
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= sdrpd_pkg::SDRPD_ST_RUN;
      active_pd <= 1'b0;
      dll_enabled <= 1'b1;
    end else begin
      case (st_q)
        sdrpd_pkg::SDRPD_ST_RUN: begin
          if (gate_prev_q && !clk_gate) begin
            if (cmd == sdrpd_pkg::SDRPD_C_RENEW && all_idle) begin
              st_q <= sdrpd_pkg::SDRPD_ST_SELF; // see R22
              dll_enabled <= 1'b0;
            end else if (nop_or_desel) begin
              st_q <= sdrpd_pkg::SDRPD_ST_PD; // see R10
              active_pd <= !all_idle; // see R13
              dll_enabled <= !all_idle && fast_exit; // see R13
            end
          end
        end
        sdrpd_pkg::SDRPD_ST_PD: begin
          if (clk_gate && nop_or_desel) begin
            st_q <= sdrpd_pkg::SDRPD_ST_RUN; // see R15
            active_pd <= 1'b0;
            dll_enabled <= 1'b1;
          end
        end
        sdrpd_pkg::SDRPD_ST_SELF: begin
          if (clk_gate && nop_or_desel) begin
            st_q <= sdrpd_pkg::SDRPD_ST_RUN; // see R22
            dll_enabled <= 1'b1;
          end
        end
        default: begin
          st_q <= sdrpd_pkg::SDRPD_ST_RUN;
          active_pd <= 1'b0;
          dll_enabled <= 1'b1;
        end
      endcase
    end
  end
  assign powered_down = (st_q == sdrpd_pkg::SDRPD_ST_PD);
  assign self_refresh = (st_q == sdrpd_pkg::SDRPD_ST_SELF);
  // ----------------------------------------------------------------
  // renew row counter and mode load
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      renew_pulse <= 1'b0;
      renew_row <= sdrpd_pkg::ROW_CNT_RST;
    end else begin
      renew_pulse <= running && cmd == sdrpd_pkg::SDRPD_C_RENEW; // see R8
      if (running && cmd == sdrpd_pkg::SDRPD_C_RENEW) begin
        renew_row <= renew_row + 1'b1; // see R8
      end
    end
  end
  // mode register select latched from bank bits
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mrl_pulse <= 1'b0;
      mrl_sel <= '0;
    end else begin
      mrl_pulse <= running && cmd == sdrpd_pkg::SDRPD_C_MRL;
      if (running && cmd == sdrpd_pkg::SDRPD_C_MRL) begin
        mrl_sel <= ba; // see R20
      end
    end
  end
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_renew_row_step: assert property (@(posedge mclk) disable iff (!arst_n)
    (running && cmd == sdrpd_pkg::SDRPD_C_RENEW) |=> renew_pulse
      && renew_row == $past(renew_row) + 1'b1) // see R8
    else $error("renew did not step row counter");
  chk_pd_entry: assert property (@(posedge mclk) disable iff (!arst_n)
    (st_q == sdrpd_pkg::SDRPD_ST_RUN && gate_prev_q && !clk_gate && nop_or_desel)
      |=> powered_down) // see R10
    else $error("power-down not entered");
  chk_pd_exit: assert property (@(posedge mclk) disable iff (!arst_n)
    (powered_down && clk_gate && nop_or_desel) |=> !powered_down && dll_enabled) // see R15
    else $error("power-down not exited");
  chk_pd_variant: assert property (@(posedge mclk) disable iff (!arst_n)
    $rose(powered_down) |-> active_pd == ($past(bank_open) != '0)) // see R13
    else $error("wrong power-down variant");
  chk_dll_precharged: assert property (@(posedge mclk) disable iff (!arst_n)
    (powered_down && !active_pd) |-> !dll_enabled) // see R13
    else $error("loop enabled in precharged power-down");
  chk_self_entry: assert property (@(posedge mclk) disable iff (!arst_n)
    (st_q == sdrpd_pkg::SDRPD_ST_RUN && gate_prev_q && !clk_gate && all_idle
      && cmd == sdrpd_pkg::SDRPD_C_RENEW) |=> self_refresh) // see R22
    else $error("self refresh not entered");
  chk_close_all: assert property (@(posedge mclk) disable iff (!arst_n)
    (running && cmd == sdrpd_pkg::SDRPD_C_CLOSE && a10) |=> all_idle) // see R19
    else $error("close all left a bank open");
  chk_act_opens: assert property (@(posedge mclk) disable iff (!arst_n)
    (running && cmd == sdrpd_pkg::SDRPD_C_ACT) |=> bank_open[$past(ba)]) // see R18
    else $error("activate did not open bank");
  chk_autoclose_time: assert property (@(posedge mclk) disable iff (!arst_n)
    (running && cmd == sdrpd_pkg::SDRPD_C_WRITE && a10 && bank_open[ba])
      ##1 (!(running && cmd == sdrpd_pkg::SDRPD_C_CLOSE)) [*8]
      |-> bank_open[$past(ba, 8)] ##1 !bank_open[$past(ba, 9)]) // see R1
    else $error("auto-close did not complete");
  chk_settle_time: assert property (@(posedge mclk) disable iff (!arst_n)
    $rose(ap_fire[0] || (running && cmd == sdrpd_pkg::SDRPD_C_CLOSE && (a10 || ba == 3'h0)))
      |=> !settled[0]) // see R6
    else $error("bank settled too early");
  cov_pd: cover property (@(posedge mclk) disable iff (!arst_n) $rose(powered_down));
  cov_apd: cover property (@(posedge mclk) disable iff (!arst_n) $rose(active_pd));
  cov_self: cover property (@(posedge mclk) disable iff (!arst_n) $rose(self_refresh));
  cov_renew: cover property (@(posedge mclk) disable iff (!arst_n) renew_pulse);
endmodule // sdrpd_top

// ===== tb/sdrpd_ctrl_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// controller model: command, gate and bank pins
// ----------------------------------------------------------------
module sdrpd_ctrl_model (
  input wire logic mclk,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic clk_gate,
  output logic a10,
  output logic [sdrpd_pkg::BA_W-1:0] ba,
  output logic fast_exit
);
  int seed;
  // idle pins: deselected, gate high through reset, junk address and exit mode
  initial begin
    seed = 11;
    cs_n = 1'h1;
    {ras_n, cas_n, we_n} = sdrpd_pkg::CMD_NOP;
    clk_gate = 1'h1;
    a10 = 1'($random(seed));
    ba = 3'($random(seed));
    fast_exit = 1'($random(seed));
  end
  // one command on a falling edge, then nop or deselect, so commands never sit back to back
  task automatic cmd(input logic [2:0] c, input logic a, input logic [2:0] b, input logic g);
    @(negedge mclk);
    cs_n = 1'h0;
    {ras_n, cas_n, we_n} = c;
    a10 = a;
    ba = b;
    clk_gate = g; // gate only changes with nop or renew
    @(negedge mclk);
    cs_n = ^b; // released: nop, or deselect over junk command bits
    {ras_n, cas_n, we_n} = cs_n ? ~c : sdrpd_pkg::CMD_NOP;
    a10 = ~a; // address released: junk, not the last value
    ba = ~b;
  endtask
  // plain waits used for spacing and settle times
  task automatic nop(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // gate level held for three registered edges with nop
  task automatic gate(input logic v);
    cmd(sdrpd_pkg::CMD_NOP, a10, ba, v);
    nop(2);
  endtask
endmodule // sdrpd_ctrl_model

// ===== tb/testbench.sv
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; $display("ERROR %0t mismatch got %h expected %h", $time, g, e); end end
module testbench;
  logic mclk, arst_n, cs_n, ras_n, cas_n, we_n, clk_gate, a10, fast_exit;
  logic all_idle, powered_down, active_pd, self_refresh, dll_enabled, renew_pulse, mrl_pulse;
  logic [sdrpd_pkg::BA_W-1:0] ba, mrl_sel, m_sel;
  logic [sdrpd_pkg::NUM_BANKS-1:0] bank_open;
  logic [sdrpd_pkg::ROW_W-1:0] renew_row;
  logic m_pd, m_apd, m_ren, m_mrl;
  int bad_count, checked, seed, row, k, ap_wait;
  int m_open[sdrpd_pkg::NUM_BANKS];
  logic [2:0] b;
  // ----------------------------------------------------------------
  // clock, partner and design
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'h0;
    forever #25 mclk = ~mclk;
  end
  sdrpd_ctrl_model ctrl (.mclk(mclk), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .clk_gate(clk_gate), .a10(a10), .ba(ba), .fast_exit(fast_exit));
  sdrpd_top #(.NUM_BANKS(sdrpd_pkg::NUM_BANKS)) DUT (.mclk(mclk), .arst_n(arst_n), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .clk_gate(clk_gate), .a10(a10), .ba(ba),
    .fast_exit(fast_exit), .bank_open(bank_open), .all_idle(all_idle),
    .powered_down(powered_down), .active_pd(active_pd), .self_refresh(self_refresh),
    .dll_enabled(dll_enabled), .renew_pulse(renew_pulse), .renew_row(renew_row),
    .mrl_pulse(mrl_pulse), .mrl_sel(mrl_sel));
  // ----------------------------------------------------------------
  // reference model and checks
  // ----------------------------------------------------------------
  function automatic logic [sdrpd_pkg::NUM_BANKS-1:0] open_vec();
    logic [sdrpd_pkg::NUM_BANKS-1:0] v;
    v = '0;
    foreach (m_open[i]) v[i] = (m_open[i] != 0);
    return v;
  endfunction
  task automatic check();
    `CHK(bank_open, open_vec())
    `CHK(all_idle, (open_vec() == 8'h00))
    `CHK(powered_down, m_pd)
    `CHK(active_pd, m_apd)
    `CHK(renew_pulse, m_ren)
    `CHK(mrl_pulse, m_mrl)
    `CHK(mrl_sel, m_sel)
  endtask
  task automatic op(input logic [2:0] c, input logic a, input logic [2:0] bb);
    ctrl.cmd(c, a, bb, 1'h1);
    if (c == sdrpd_pkg::CMD_ACT) m_open[bb] = 1;
    if (c == sdrpd_pkg::CMD_CLOSE && a) foreach (m_open[i]) m_open[i] = 0;
    if (c == sdrpd_pkg::CMD_CLOSE && !a) m_open[bb] = 0;
    m_ren = (c == sdrpd_pkg::CMD_RENEW);
    m_mrl = (c == sdrpd_pkg::CMD_MRL);
    if (m_mrl) m_sel = bb;
    check();
    m_ren = 1'h0;
    m_mrl = 1'h0;
  endtask
  task automatic pd(input logic v);
    ctrl.gate(v);
    m_pd = ~v;
    m_apd = ~v & (open_vec() != 8'h00);
    check();
  endtask
  task automatic stop_test();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // watchdog far beyond the hundred or so cycles the sequence needs
  initial begin
    repeat (5000) @(posedge mclk);
    bad_count++;
    $display("ERROR %0t watchdog expired", $time);
    stop_test();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 11;
    {bad_count, checked, row} = '0;
    {m_pd, m_apd, m_ren, m_mrl} = 4'h0;
    m_sel = 3'h0;
    foreach (m_open[i]) m_open[i] = 0;
    arst_n = 1'h0;
    repeat (5) @(negedge mclk);
    arst_n = 1'h1;
    check();
    `CHK(dll_enabled, 1'h1)
    // random banks open, one closed alone, rest closed together
    for (int i = 0; i < 8; i++) if ($random(seed) & 1) op(sdrpd_pkg::CMD_ACT, 1'h0, 3'(i));
    b = 3'($random(seed));
    if (m_open[b] == 0) op(sdrpd_pkg::CMD_ACT, 1'h0, b);
    op(sdrpd_pkg::CMD_CLOSE, 1'h0, b);
    op(sdrpd_pkg::CMD_CLOSE, 1'h1, 3'($random(seed)));
    ctrl.nop(2);
    // plain write keeps the bank, auto-close write drops it after the burst
    op(sdrpd_pkg::CMD_ACT, 1'h0, b);
    op(sdrpd_pkg::CMD_WRITE, 1'h0, b);
    ctrl.nop(8);
    check();
    op(sdrpd_pkg::CMD_READ, 1'h0, b);
    ctrl.nop(4);
    op(sdrpd_pkg::CMD_CLOSE, 1'h0, b);
    ctrl.nop(2);
    op(sdrpd_pkg::CMD_ACT, 1'h0, b);
    op(sdrpd_pkg::CMD_WRITE, 1'h1, b);
    k = 0;
    while (bank_open[b] === 1'h1 && k < 20) begin
      @(negedge mclk);
      k++;
    end
    ap_wait = sdrpd_pkg::WRITE_DELAY_CYC + sdrpd_pkg::BURST_SIZE / 2
      + sdrpd_pkg::POST_STORE_DELAY_CYC;
    `CHK(k, ap_wait)
    m_open[b] = 0;
    check();
    ctrl.nop(3);
    // refresh bursts: pulse and internal row count
    repeat (1 + ($random(seed) & 3)) begin
      op(sdrpd_pkg::CMD_RENEW, 1'h0, 3'($random(seed)));
      row++;
      ctrl.nop(1);
      check();
      `CHK(renew_row, row[sdrpd_pkg::ROW_W-1:0])
    end
    // mode loads with random register select
    repeat (3) op(sdrpd_pkg::CMD_MRL, 1'h0, 3'($random(seed)));
    // precharged power-down, then active with slow and fast exit
    ctrl.fast_exit = 1'($random(seed));
    pd(1'h0);
    `CHK(dll_enabled, 1'h0)
    pd(1'h1);
    op(sdrpd_pkg::CMD_MRL, 1'h0, 3'h0);
    op(sdrpd_pkg::CMD_ACT, 1'h0, b);
    for (int f = 0; f < 2; f++) begin
      ctrl.fast_exit = 1'(f);
      pd(1'h0);
      `CHK(dll_enabled, 1'(f))
      pd(1'h1);
    end
    // self refresh from all idle, left with a gate rise
    op(sdrpd_pkg::CMD_CLOSE, 1'h1, 3'h0);
    ctrl.nop(2);
    ctrl.cmd(sdrpd_pkg::CMD_RENEW, a10, ba, 1'h0);
    ctrl.nop(2);
    `CHK(self_refresh, 1'h1)
    ctrl.gate(1'h1);
    `CHK(self_refresh, 1'h0)
    `CHK(bank_open, 8'h00)
    stop_test();
  end
endmodule // testbench
